// file: rtl/fan_thermal_pkg.sv
// Shared constants for the fan thermal threshold register bank.
package fan_thermal_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int unsigned NUM_CHAN   = 3;
    localparam int unsigned REG_W      = 8;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned RAW_W      = 10;
    localparam int unsigned TEMP_W     = 12;
    localparam int unsigned HYST_W     = 4;
    localparam int unsigned SPAN_W     = 3;

    // ------------------------------------------------------------------
    // Channel indices
    // ------------------------------------------------------------------
    localparam int unsigned CH_REMOTE1 = 0;
    localparam int unsigned CH_LOCAL   = 1;
    localparam int unsigned CH_REMOTE2 = 2;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_REMOTE1_START = 8'h67;
    localparam logic [ADDR_W-1:0] ADDR_LOCAL_START   = 8'h68;
    localparam logic [ADDR_W-1:0] ADDR_REMOTE2_START = 8'h69;
    localparam logic [ADDR_W-1:0] ADDR_REMOTE1_CRIT  = 8'h6a;
    localparam logic [ADDR_W-1:0] ADDR_LOCAL_CRIT    = 8'h6b;
    localparam logic [ADDR_W-1:0] ADDR_REMOTE2_CRIT  = 8'h6c;
    localparam logic [ADDR_W-1:0] ADDR_R1_LOCAL_HYST = 8'h6d;
    localparam logic [ADDR_W-1:0] ADDR_REMOTE2_HYST  = 8'h6e;
    localparam logic [ADDR_W-1:0] ADDR_TREE_TEST     = 8'h6f;
    localparam logic [ADDR_W-1:0] ADDR_REMOTE1_OFFS  = 8'h70;

    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [REG_W-1:0] RST_START        = 8'h5a;
    localparam logic [REG_W-1:0] RST_CRIT         = 8'h64;
    localparam logic [REG_W-1:0] RST_R1_LOCAL_HYS = 8'h44;
    localparam logic [REG_W-1:0] RST_REMOTE2_HYS  = 8'h40;
    localparam logic [REG_W-1:0] RST_TREE_TEST    = 8'h00;
    localparam logic [REG_W-1:0] RST_OFFSET       = 8'h00;
    localparam logic [REG_W-1:0] CRIT_DISABLE     = 8'h80;
    localparam logic [REG_W-1:0] DUTY_FULL        = 8'hff;
    localparam logic [REG_W-1:0] DUTY_OFF         = 8'h00;
    localparam int unsigned      LOCAL_HYST_LSB   = 0;
    localparam int unsigned      REMOTE1_HYST_LSB = 4;
    localparam int unsigned      REMOTE2_HYST_LSB = 4;
    localparam int unsigned      TREE_TEST_BIT    = 0;
    // Temperatures are carried in quarter degrees.
    localparam int unsigned      FRAC_BITS        = 2;

endpackage

// file: rtl/chan_if.sv
// Interface carrying one temperature channel's settings and results.
`timescale 1ns/100ps
interface chan_if;
    import fan_thermal_pkg::*;

    logic                     temp_valid;
    logic signed [TEMP_W-1:0] temp;
    logic [REG_W-1:0]         start_temp;
    logic [REG_W-1:0]         crit_limit;
    logic [HYST_W-1:0]        hyst;
    logic [REG_W-1:0]         min_duty;
    logic [SPAN_W-1:0]        ramp_span;
    logic                     fan_on;
    logic                     crit;
    logic                     over_limit;
    logic [REG_W-1:0]         duty;

    modport ctrl (output temp_valid, temp, start_temp, crit_limit, hyst, min_duty, ramp_span,
                  input  fan_on, crit, over_limit, duty);
    modport chan (input  temp_valid, temp, start_temp, crit_limit, hyst, min_duty, ramp_span,
                  output fan_on, crit, over_limit, duty);
endinterface

// file: rtl/chan_ctrl.sv
// Threshold, hysteresis and ramp evaluation for one temperature channel.
`timescale 1ns/100ps
module chan_ctrl (
    input  wire logic mclk_in,
    input  wire logic rst_b_in,
    chan_if.chan      ch
);
    import fan_thermal_pkg::*;

    // ------------------------------------------------------------------
    // Thresholds in quarter degrees
    // ------------------------------------------------------------------
    logic signed [TEMP_W-1:0] start_q4;
    logic signed [TEMP_W-1:0] crit_q4;
    logic signed [TEMP_W-1:0] hyst_q4;
    logic signed [TEMP_W-1:0] above;
    logic [17:0]              ramp_prod;
    logic [17:0]              ramp_step;
    logic [17:0]              ramp_sum;
    logic [REG_W-1:0]         ramp_duty;
    logic                     crit_enabled;
    logic                     start_set;
    logic                     start_clr;
    logic                     crit_set;
    logic                     crit_clr;
    logic                     fan_on_q;
    logic                     crit_q;
    logic                     over_q;
    logic [REG_W-1:0]         duty_q;
    logic [REG_W-1:0]         duty_d;

    assign start_q4 = TEMP_W'({{(TEMP_W-REG_W-FRAC_BITS){ch.start_temp[REG_W-1]}}, ch.start_temp, 2'b00});
    assign crit_q4  = TEMP_W'({{(TEMP_W-REG_W-FRAC_BITS){ch.crit_limit[REG_W-1]}}, ch.crit_limit, 2'b00});
    assign hyst_q4  = TEMP_W'({{(TEMP_W-HYST_W-FRAC_BITS){1'b0}}, ch.hyst, 2'b00});

    assign start_set    = ch.temp > start_q4;
    // Release only at start minus hysteresis.
    assign start_clr    = ch.temp <= (start_q4 - hyst_q4);
    assign crit_enabled = ch.crit_limit != CRIT_DISABLE;
    assign crit_set     = crit_enabled && (ch.temp > crit_q4);
    assign crit_clr     = ch.temp < (crit_q4 - hyst_q4);

    // ------------------------------------------------------------------
    // Ramp above the start threshold
    // ------------------------------------------------------------------
    assign above     = ch.temp - start_q4;
    assign ramp_prod = 18'(DUTY_FULL - ch.min_duty) * 18'(above[9:0]);
    // Span codes above four need a shift wider than the code itself.
    assign ramp_step = ramp_prod >> (4'(ch.ramp_span) + 4'd3);
    assign ramp_sum  = 18'(ch.min_duty) + ramp_step;
    assign ramp_duty = (ramp_sum > 18'(DUTY_FULL)) ? DUTY_FULL : ramp_sum[REG_W-1:0];

    always_comb begin
        if (!fan_on_q && !start_set) begin
            duty_d = DUTY_OFF;
        end else if (start_set) begin
            duty_d = ramp_duty;
        end else begin
            duty_d = ch.min_duty;
        end
    end

    // ------------------------------------------------------------------
    // State, updated once per new conversion
    // ------------------------------------------------------------------
    // Re-evaluate on each new result.
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fan_on_q <= 1'b0;
            crit_q   <= 1'b0;
            over_q   <= 1'b0;
            duty_q   <= DUTY_OFF;
        end else if (ch.temp_valid) begin
            fan_on_q <= start_set || (fan_on_q && !start_clr);
            crit_q   <= crit_set || (crit_q && crit_enabled && !crit_clr);
            over_q   <= crit_set;
            duty_q   <= (start_set || !start_clr) ? duty_d : DUTY_OFF;
        end
    end

    assign ch.fan_on     = fan_on_q;
    assign ch.crit       = crit_q;
    assign ch.over_limit = over_q;
    assign ch.duty       = duty_q;

endmodule

// file: rtl/fan_thermal_threshold_regs.sv
// Fan start, critical limit, hysteresis, offset and test registers with fan protection.
//
// Contract
// - Three fan start thresholds, each reset to 90 degrees.
// - Above start threshold fan runs at minimum duty, rising over ramp span.
// - Lock bit makes every register read-only; writes ignored.
// - Any channel above its critical limit forces all PWM outputs full.
// - Critical limit 0x80 disables that channel's forced full duty.
// - Full duty held until temperature drops below limit minus hysteresis.
// - Overtemperature pin as output driven low a quarter degree over limit.
// - Three critical limits, each reset to 100 degrees.
// - Shared hysteresis: local low nibble, remote 1 high nibble, reset 0x44.
// - Remote 2 hysteresis register, reset 0x40.
// - Below start, fan stays at minimum duty until start minus hysteresis.
// - Hysteresis is four bits, 0 to 15 degrees.
// - Same hysteresis applies to start release and critical release.
// - Test enable bit 0 enters pin tree test mode; resets to zero.
// - Remote 1 offset added to measurements; range selected; resets zero.
// - Minimum duty linear: zero off, all ones full speed.
`timescale 1ns/100ps
module fan_thermal_threshold_regs (
    input  wire logic                                                       mclk_in,
    input  wire logic                                                       rst_b_in,
    input  wire logic [fan_thermal_pkg::ADDR_W-1:0]                         reg_addr_in,
    input  wire logic                                                       reg_wr_in,
    input  wire logic [fan_thermal_pkg::REG_W-1:0]                          reg_wdata_in,
    input  wire logic                                                       reg_rd_in,
    output logic      [fan_thermal_pkg::REG_W-1:0]                          reg_rdata_out,
    input  wire logic                                                       cfg_lock_in,
    input  wire logic                                                       offset_coarse_in,
    input  wire logic [fan_thermal_pkg::NUM_CHAN-1:0]                       temp_valid_in,
    input  wire logic [fan_thermal_pkg::NUM_CHAN-1:0][fan_thermal_pkg::RAW_W-1:0] temp_raw_in,
    input  wire logic [fan_thermal_pkg::NUM_CHAN-1:0][fan_thermal_pkg::REG_W-1:0] min_fan_duty_in,
    input  wire logic [fan_thermal_pkg::NUM_CHAN-1:0][fan_thermal_pkg::SPAN_W-1:0] fan_ramp_span_in,
    input  wire logic                                                       overtemp_pin_is_output_in,
    input  wire logic                                                       overtemp_pin_in,
    output logic                                                            overtemp_pin_out,
    output logic                                                            overtemp_pin_oe_b_out,
    output logic [fan_thermal_pkg::NUM_CHAN-1:0][fan_thermal_pkg::REG_W-1:0] fan_duty_out,
    output logic [fan_thermal_pkg::NUM_CHAN-1:0]                            fan_active_out,
    output logic                                                            full_duty_forced_out,
    output logic                                                            tree_test_enable_out
);
    import fan_thermal_pkg::*;

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [NUM_CHAN-1:0][REG_W-1:0] start_q;
    logic [NUM_CHAN-1:0][REG_W-1:0] crit_q;
    logic [REG_W-1:0]               hyst_r1_local_q;
    logic [REG_W-1:0]               hyst_r2_q;
    logic                           tree_test_q;
    logic [REG_W-1:0]               r1_offset_q;
    logic [REG_W-1:0]               rdata_q;
    logic [REG_W-1:0]               rdata_d;
    logic [NUM_CHAN-1:0][REG_W-1:0] duty_q;
    logic [NUM_CHAN-1:0]            active_q;
    logic                           forced_q;
    logic                           pin_low_q;

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    logic                           wr_ok;
    logic [NUM_CHAN-1:0]            wr_start;
    logic [NUM_CHAN-1:0]            wr_crit;
    logic                           wr_hyst_a;
    logic                           wr_hyst_b;
    logic                           wr_tree;
    logic                           wr_offs;

    assign wr_ok     = reg_wr_in && !cfg_lock_in;
    assign wr_start  = {wr_ok && (reg_addr_in == ADDR_REMOTE2_START),
                        wr_ok && (reg_addr_in == ADDR_LOCAL_START),
                        wr_ok && (reg_addr_in == ADDR_REMOTE1_START)};
    assign wr_crit   = {wr_ok && (reg_addr_in == ADDR_REMOTE2_CRIT),
                        wr_ok && (reg_addr_in == ADDR_LOCAL_CRIT),
                        wr_ok && (reg_addr_in == ADDR_REMOTE1_CRIT)};
    assign wr_hyst_a = wr_ok && (reg_addr_in == ADDR_R1_LOCAL_HYST);
    assign wr_hyst_b = wr_ok && (reg_addr_in == ADDR_REMOTE2_HYST);
    assign wr_tree   = wr_ok && (reg_addr_in == ADDR_TREE_TEST);
    assign wr_offs   = wr_ok && (reg_addr_in == ADDR_REMOTE1_OFFS);

    // ------------------------------------------------------------------
    // Threshold registers
    // ------------------------------------------------------------------
    // Start thresholds reset to 90 degrees.
    // Critical limits reset to 100 degrees.
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            start_q <= {NUM_CHAN{RST_START}};
            crit_q  <= {NUM_CHAN{RST_CRIT}};
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (wr_start[i]) begin
                    start_q[i] <= reg_wdata_in;
                end
                if (wr_crit[i]) begin
                    crit_q[i] <= reg_wdata_in;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Hysteresis, test and offset registers
    // ------------------------------------------------------------------
    // Shared hysteresis register.
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hyst_r1_local_q <= RST_R1_LOCAL_HYS;
            hyst_r2_q       <= RST_REMOTE2_HYS;
            tree_test_q     <= RST_TREE_TEST[TREE_TEST_BIT];
            r1_offset_q     <= RST_OFFSET;
        end else begin
            if (wr_hyst_a) begin
                hyst_r1_local_q <= reg_wdata_in;
            end
            if (wr_hyst_b) begin
                hyst_r2_q <= reg_wdata_in;
            end
            if (wr_tree) begin
                tree_test_q <= reg_wdata_in[TREE_TEST_BIT];
            end
            if (wr_offs) begin
                r1_offset_q <= reg_wdata_in;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Unused test-enable bits read as zero; unmapped offsets read zero.
    always_comb begin
        case (reg_addr_in)
            ADDR_REMOTE1_START: rdata_d = start_q[CH_REMOTE1];
            ADDR_LOCAL_START:   rdata_d = start_q[CH_LOCAL];
            ADDR_REMOTE2_START: rdata_d = start_q[CH_REMOTE2];
            ADDR_REMOTE1_CRIT:  rdata_d = crit_q[CH_REMOTE1];
            ADDR_LOCAL_CRIT:    rdata_d = crit_q[CH_LOCAL];
            ADDR_REMOTE2_CRIT:  rdata_d = crit_q[CH_REMOTE2];
            ADDR_R1_LOCAL_HYST: rdata_d = hyst_r1_local_q;
            ADDR_REMOTE2_HYST:  rdata_d = hyst_r2_q;
            ADDR_TREE_TEST:     rdata_d = {{(REG_W-1){1'b0}}, tree_test_q};
            ADDR_REMOTE1_OFFS:  rdata_d = r1_offset_q;
            default:            rdata_d = {REG_W{1'b0}};
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_q <= {REG_W{1'b0}};
        end else if (reg_rd_in) begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Offset correction
    // ------------------------------------------------------------------
    logic signed [TEMP_W-1:0] r1_offs_ext;
    logic signed [TEMP_W-1:0] r1_offs_q4;
    logic signed [TEMP_W-1:0] raw_ext [NUM_CHAN];
    logic signed [TEMP_W-1:0] corr    [NUM_CHAN];

    // Coarse range counts whole degrees, fine range quarter degrees.
    assign r1_offs_ext = TEMP_W'({{(TEMP_W-REG_W){r1_offset_q[REG_W-1]}}, r1_offset_q});
    assign r1_offs_q4  = offset_coarse_in ? (r1_offs_ext <<< FRAC_BITS) : r1_offs_ext;

    generate
        for (genvar g = 0; g < NUM_CHAN; g++) begin : g_corr
            assign raw_ext[g] = TEMP_W'({{(TEMP_W-RAW_W){temp_raw_in[g][RAW_W-1]}}, temp_raw_in[g]});
        end
    endgenerate

    // Offset added to remote 1 only.
    assign corr[CH_REMOTE1] = raw_ext[CH_REMOTE1] + r1_offs_q4;
    assign corr[CH_LOCAL]   = raw_ext[CH_LOCAL];
    assign corr[CH_REMOTE2] = raw_ext[CH_REMOTE2];

    // ------------------------------------------------------------------
    // Channel evaluators
    // ------------------------------------------------------------------
    logic [HYST_W-1:0]   hyst_sel [NUM_CHAN];
    logic [NUM_CHAN-1:0] ch_crit;
    logic [NUM_CHAN-1:0] ch_over;
    logic [NUM_CHAN-1:0] ch_on;
    logic [REG_W-1:0]    ch_duty  [NUM_CHAN];

    assign hyst_sel[CH_REMOTE1] = hyst_r1_local_q[REMOTE1_HYST_LSB +: HYST_W];
    assign hyst_sel[CH_LOCAL]   = hyst_r1_local_q[LOCAL_HYST_LSB +: HYST_W];
    assign hyst_sel[CH_REMOTE2] = hyst_r2_q[REMOTE2_HYST_LSB +: HYST_W];

    generate
        for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
            chan_if ch_bus ();

            assign ch_bus.temp_valid = temp_valid_in[g];
            assign ch_bus.temp       = corr[g];
            assign ch_bus.start_temp = start_q[g];
            assign ch_bus.crit_limit = crit_q[g];
            assign ch_bus.hyst       = hyst_sel[g];
            assign ch_bus.min_duty   = min_fan_duty_in[g];
            assign ch_bus.ramp_span  = fan_ramp_span_in[g];
            assign ch_crit[g]        = ch_bus.crit;
            assign ch_over[g]        = ch_bus.over_limit;
            assign ch_on[g]          = ch_bus.fan_on;
            assign ch_duty[g]        = ch_bus.duty;

            chan_ctrl u_chan (
                .mclk_in  (mclk_in),
                .rst_b_in (rst_b_in),
                .ch       (ch_bus.chan)
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Fan duty outputs and overtemperature pin
    // ------------------------------------------------------------------
    logic any_crit;
    logic pin_low_d;

    // Any critical channel forces all fans.
    // Held by each channel until its release point.
    assign any_crit  = |ch_crit;
    // Pin driven low when enabled as output.
    assign pin_low_d = overtemp_pin_is_output_in && (|ch_over);

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            duty_q    <= {NUM_CHAN{DUTY_OFF}};
            active_q  <= {NUM_CHAN{1'b0}};
            forced_q  <= 1'b0;
            pin_low_q <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                duty_q[i] <= any_crit ? DUTY_FULL : ch_duty[i];
            end
            active_q  <= ch_on;
            forced_q  <= any_crit;
            pin_low_q <= pin_low_d;
        end
    end

    assign reg_rdata_out         = rdata_q;
    assign fan_duty_out          = duty_q;
    assign fan_active_out        = active_q;
    assign full_duty_forced_out  = forced_q;
    assign overtemp_pin_out      = 1'b0;
    assign overtemp_pin_oe_b_out = !pin_low_q;
    assign tree_test_enable_out  = tree_test_q;

endmodule

// file: tb/fan_regs_checker.sv
// Port level checks for the fan thermal threshold register bank.
`timescale 1ns/100ps
module fan_regs_checker (
    input wire logic            mclk_in,
    input wire logic            rst_b_in,
    input wire logic [7:0]      reg_addr_in,
    input wire logic            reg_wr_in,
    input wire logic            reg_rd_in,
    input wire logic [7:0]      reg_rdata_out,
    input wire logic            cfg_lock_in,
    input wire logic [2:0]      temp_valid_in,
    input wire logic            overtemp_pin_out,
    input wire logic            overtemp_pin_oe_b_out,
    input wire logic [2:0][7:0] fan_duty_out,
    input wire logic [2:0]      fan_active_out,
    input wire logic            full_duty_forced_out,
    input wire logic            tree_test_enable_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    property p_force_full;
        full_duty_forced_out |-> fan_duty_out == {3{8'hff}};
    endproperty
    a_force_full: assert property (p_force_full) else $error("forced state without full duty");
    property p_oe_cause;
        !overtemp_pin_oe_b_out |-> full_duty_forced_out;
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("overtemp pin low without critical");
    property p_od_data;
        overtemp_pin_out == 1'b0;
    endproperty
    a_od_data: assert property (p_od_data) else $error("overtemp pin data not low");
    property p_duty_upd;
        $changed(fan_duty_out) |-> $past(|temp_valid_in, 2);
    endproperty
    a_duty_upd: assert property (p_duty_upd) else $error("duty moved without new result");
    property p_active_upd;
        $changed(fan_active_out) |-> $past(|temp_valid_in, 2);
    endproperty
    a_active_upd: assert property (p_active_upd) else $error("fan state moved without new result");
    property p_forced_upd;
        $changed(full_duty_forced_out) |-> $past(|temp_valid_in, 2);
    endproperty
    a_forced_upd: assert property (p_forced_upd) else $error("forced moved without new result");
    property p_lock_tt;
        $changed(tree_test_enable_out) |-> $past(reg_wr_in && !cfg_lock_in && reg_addr_in == 8'h6f);
    endproperty
    a_lock_tt: assert property (p_lock_tt) else $error("test enable moved without open write");
    property p_tt_rsvd;
        reg_rd_in && reg_addr_in == 8'h6f |=> reg_rdata_out == {7'h00, tree_test_enable_out};
    endproperty
    a_tt_rsvd: assert property (p_tt_rsvd) else $error("test enable read wrong");
    property p_unmapped;
        reg_rd_in && (reg_addr_in < 8'h67 || reg_addr_in > 8'h70) |=> reg_rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    c_forced: cover property ($rose(full_duty_forced_out));
    c_fan_off: cover property ($fell(fan_active_out[1]));
    c_test: cover property ($rose(tree_test_enable_out));
endmodule

// file: tb/host_model.sv
// Host software model that reaches the registers through the strobe port.
`timescale 1ns/100ps
module host_model (
    input  wire logic       mclk_in,
    input  wire logic [7:0] rdata_in,
    output logic      [7:0] addr_out = 8'h00,
    output logic            wr_out = 1'b0,
    output logic      [7:0] wdata_out = 8'h00,
    output logic            rd_out = 1'b0
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_in);
        addr_out = a;
        wdata_out = (a == 8'h6f) ? (d & 8'h01) : d;
        wr_out = 1'b1;
        @(negedge mclk_in);
        wr_out = 1'b0;
        wdata_out = ~wdata_out;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk_in);
        addr_out = a;
        rd_out = 1'b1;
        @(negedge mclk_in);
        rd_out = 1'b0;
        d = rdata_in;
    endtask
endmodule

// file: tb/tb.sv
// Testbench for the fan thermal threshold register bank.
`timescale 1ns/100ps
module tb;
    logic            mclk_in = 1'b0;
    logic            rst_b_in = 1'b0;
    logic            cfg_lock_in = 1'b0;
    logic            offset_coarse_in = 1'b0;
    logic [2:0]      temp_valid_in = '0;
    logic [2:0][9:0] temp_raw_in = '0;
    logic [2:0][7:0] min_fan_duty_in = {3{8'h40}};
    logic [2:0][2:0] fan_ramp_span_in = '0;
    logic [7:0]      reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic            reg_wr_in, reg_rd_in, overtemp_pin_out, overtemp_pin_oe_b_out;
    logic [2:0][7:0] fan_duty_out;
    logic [2:0]      fan_active_out;
    logic            full_duty_forced_out, tree_test_enable_out;
    int              num_errors = 0;
    int              num_checks = 0;
    logic [7:0]      rst_tab [10] = '{8'h5a, 8'h5a, 8'h5a, 8'h64, 8'h64, 8'h64, 8'h44, 8'h40, 8'h00, 8'h00};
    initial forever #5 mclk_in = ~mclk_in;
    host_model host (.mclk_in, .rdata_in(reg_rdata_out), .addr_out(reg_addr_in), .wr_out(reg_wr_in),
                     .wdata_out(reg_wdata_in), .rd_out(reg_rd_in));
    fan_thermal_threshold_regs uut (.mclk_in, .rst_b_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rd_in,
        .reg_rdata_out, .cfg_lock_in, .offset_coarse_in, .temp_valid_in, .temp_raw_in, .min_fan_duty_in,
        .fan_ramp_span_in, .overtemp_pin_is_output_in(1'b1), .overtemp_pin_in(overtemp_pin_oe_b_out),
        .overtemp_pin_out, .overtemp_pin_oe_b_out, .fan_duty_out, .fan_active_out, .full_duty_forced_out,
        .tree_test_enable_out);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        host.rd(a, v);
        chk(v, e);
    endtask
    // Outputs settle one edge after the edge that takes the result.
    task automatic temp(input int c, input logic [9:0] t);
        @(negedge mclk_in);
        temp_valid_in[c] = 1'b1;
        temp_raw_in[c] = t;
        @(negedge mclk_in);
        temp_valid_in = '0;
        repeat (2) @(negedge mclk_in);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge mclk_in);
        rst_b_in = 1'b1;
        for (int i = 0; i < 10; i++) rchk(8'h67 + 8'(i), rst_tab[i]);
        rchk(8'h71, 8'h00);
        host.wr(8'h6f, 8'hff);
        rchk(8'h6f, 8'h01);
        chk({7'h00, tree_test_enable_out}, 8'h01);
        cfg_lock_in = 1'b1;
        host.wr(8'h6f, 8'h00);
        host.wr(8'h6b, 8'h50);
        rchk(8'h6b, 8'h64);
        chk({7'h00, tree_test_enable_out}, 8'h01);
        cfg_lock_in = 1'b0;
        host.wr(8'h6f, 8'h00);
        $display("test registers done");
        temp(1, 10'd404);
        chk(fan_duty_out[0] & fan_duty_out[1] & fan_duty_out[2], 8'hff);
        chk({full_duty_forced_out, overtemp_pin_oe_b_out, 6'h00}, 8'h80);
        temp(1, 10'd385);
        chk({7'h00, full_duty_forced_out}, 8'h01);
        temp(1, 10'd383);
        chk({full_duty_forced_out, overtemp_pin_oe_b_out, 6'h00}, 8'h40);
        host.wr(8'h6b, 8'h80);
        temp(1, 10'd404);
        chk({7'h00, full_duty_forced_out}, 8'h00);
        host.wr(8'h70, 8'h08);
        temp(0, 10'd396);
        chk({7'h00, full_duty_forced_out}, 8'h01);
        temp(0, 10'd200);
        chk({7'h00, full_duty_forced_out}, 8'h00);
        offset_coarse_in = 1'b1;
        temp(0, 10'd380);
        chk({7'h00, full_duty_forced_out}, 8'h01);
        offset_coarse_in = 1'b0;
        temp(0, 10'd200);
        temp(1, 10'd200);
        $display("test critical done");
        temp(1, 10'd361);
        chk(fan_duty_out[1], 8'h57);
        temp(1, 10'd345);
        chk(fan_duty_out[1], 8'h40);
        chk({7'h00, fan_active_out[1]}, 8'h01);
        temp(1, 10'd344);
        chk({7'h00, fan_active_out[1]}, 8'h00);
        host.wr(8'h6d, 8'h4f);
        temp(1, 10'd361);
        temp(1, 10'd301);
        chk({7'h00, fan_active_out[1]}, 8'h01);
        temp(1, 10'd300);
        chk({7'h00, fan_active_out[1]}, 8'h00);
        fan_ramp_span_in[1] = 3'd5;
        temp(1, 10'd511);
        chk(fan_duty_out[1], 8'hb0);
        $display("test start threshold done");
        results();
    end
    initial begin
        #200000;
        num_errors++;
        results();
    end
endmodule
bind fan_thermal_threshold_regs fan_regs_checker chk_i (.mclk_in, .rst_b_in, .reg_addr_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .cfg_lock_in, .temp_valid_in, .overtemp_pin_out, .overtemp_pin_oe_b_out,
    .fan_duty_out, .fan_active_out, .full_duty_forced_out, .tree_test_enable_out);
